// >>> sm_exec_pkg.sv
// shared constants and types for the shift and move execution block
package sm_exec_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_WORK = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BANK = 8'h0C;
  localparam logic [7:0] OFF_PAGE = 8'h10;
  localparam logic [7:0] OFF_PTR0 = 8'h14;
  localparam logic [7:0] OFF_PTR1 = 8'h18;
  localparam logic [7:0] OFF_MEM_ADDR = 8'h1C;
  localparam logic [7:0] OFF_MEM_DATA = 8'h20;

  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int STATUS_C_BIT = 0;
  localparam int STATUS_Z_BIT = 2;
  localparam int BANK_W = 5;
  localparam int PAGE_W = 7;
  localparam int FILE_W = 7;
  localparam int PTR_W = 16;
  localparam logic [FILE_W-1:0] WINDOW0_ADDR = 7'h00;
  localparam logic [FILE_W-1:0] WINDOW1_ADDR = 7'h01;
  localparam logic [3:0] STRB_ALL = 4'hF;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST = 7'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;

  // ---------------------------------------------------------------
  // opcodes and pointer modes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_SHIFT_RIGHT = 8'h01;
  localparam logic [7:0] OP_IND_LOAD = 8'h02;
  localparam logic [7:0] OP_BANK_LIT = 8'h03;
  localparam logic [7:0] OP_PAGE_LIT = 8'h04;
  localparam logic [7:0] OP_WORK_LIT = 8'h05;
  localparam logic [7:0] OP_STORE_WORK = 8'h06;
  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // instruction word written to the instruction register
  typedef struct packed {
    logic [4:0] spare;
    logic [5:0] offset;
    logic rel;
    logic [1:0] pointer_mode_code;
    logic sel;
    logic dest;
    logic [7:0] literal;
    logic [7:0] opcode;
  } instr_type;

  // carry and zero flags
  typedef struct packed {
    logic z;
    logic c;
  } flags_type;

endpackage : sm_exec_pkg

// >>> shift_unit.sv
// right shift with zero into bit 7 and bit 0 into carry, and zero detection
`timescale 1ns/1ps
module shift_unit (
  // operands
  input wire logic [7:0] operand,
  input wire logic [7:0] load_value,
  // results
  output logic [7:0] shift_result,
  output logic shift_carry,
  output logic shift_zero,
  output logic load_zero
);

  // zero into bit 7, bit 0 into carry
  assign shift_result = {1'b0, operand[7:1]};
  assign shift_carry = operand[0];
  assign shift_zero = (shift_result == 8'h00);
  assign load_zero = (load_value == 8'h00);

endmodule : shift_unit

// >>> pointer_unit.sv
// effective address and pointer update for indirect access
`timescale 1ns/1ps
module pointer_unit (
  // pointer and mode
  input wire logic [15:0] ptr,
  input wire logic [1:0] pointer_mode_code,
  input wire logic rel,
  input wire logic [5:0] offset,
  // results
  output logic [15:0] eff_addr,
  output logic [15:0] nxt_ptr
);

  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] ptr_rel;

  // 16-bit arithmetic wraps at both ends
  assign ptr_inc = ptr + 16'h0001;
  assign ptr_dec = ptr - 16'h0001;
  assign ptr_rel = ptr + {{10{offset[5]}}, offset};

  // mode select
  always_comb begin
    eff_addr = ptr;
    nxt_ptr = ptr;
    if (rel) begin
      eff_addr = ptr_rel;
      nxt_ptr = ptr;
    end else begin
      case (pointer_mode_code)
        sm_exec_pkg::MODE_PRE_INC: begin
          eff_addr = ptr_inc;
          nxt_ptr = ptr_inc;
        end
        sm_exec_pkg::MODE_PRE_DEC: begin
          eff_addr = ptr_dec;
          nxt_ptr = ptr_dec;
        end
        sm_exec_pkg::MODE_POST_INC: begin
          nxt_ptr = ptr_inc;
        end
        default: begin
          nxt_ptr = ptr_dec;
        end
      endcase
    end
  end

endmodule : pointer_unit

// >>> shift_and_move_instruction_exec.sv
// execution of shift, indirect load and move instructions behind apb
//
// Summary of operation
// - right shift puts bits 7..1 in 6..0, zero in bit 7, bit 0 in carry.
// - shift destination 0 writes the work register, 1 the file register.
// - an access to an indirect window goes to the address in its pointer.
// - indirect load copies the byte at the effective address into work.
// - mode 00/01/10/11 is pre-inc, pre-dec, post-inc, post-dec by one.
// - relative mode uses pointer plus signed -32..31, pointer unchanged.
// - pointers are 16 bits and wrap past FFFFh and 0000h.
// - bank literal load writes five bits to bank select, flags kept.
// - page literal load writes seven bits to the upper latch, flags kept.
// - work literal load writes eight bits to work, flags kept.
// - store copies work into the addressed file register, flags kept.
`timescale 1ns/1ps
module shift_and_move_instruction_exec #(
  parameter int MEM_AW = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] mem [2**MEM_AW];
  logic [7:0] work_ff;
  sm_exec_pkg::flags_type flags_ff;
  logic [sm_exec_pkg::BANK_W-1:0] bank_select_register_ff;
  logic [sm_exec_pkg::PAGE_W-1:0] program_counter_upper_latch_ff;
  logic [15:0] file_pointer_ff [2];
  logic [MEM_AW-1:0] mem_addr_ff;
  logic [31:0] prdata_ff;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic setup;
  logic wr;
  logic mapped;
  logic [31:0] rd_value;
  logic exec;
  sm_exec_pkg::instr_type instr;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & pstrb[0];
  assign exec = psel & penable & pwrite & (pstrb == sm_exec_pkg::STRB_ALL)
                & (paddr == sm_exec_pkg::OFF_INSTR);
  assign instr = sm_exec_pkg::instr_type'(pwdata);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_ff;

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  logic [sm_exec_pkg::FILE_W-1:0] file_reg;
  logic is_window;
  logic [15:0] file_addr;
  logic [MEM_AW-1:0] file_idx;
  logic [7:0] operand;
  logic [15:0] sel_ptr;
  logic [15:0] eff_addr;
  logic [15:0] nxt_ptr;
  logic [7:0] ind_data;
  logic [7:0] shift_result;
  logic shift_carry;
  logic shift_zero;
  logic load_zero;

  assign file_reg = instr.literal[sm_exec_pkg::FILE_W-1:0];
  assign is_window = (file_reg == sm_exec_pkg::WINDOW0_ADDR) ||
                     (file_reg == sm_exec_pkg::WINDOW1_ADDR);
  // window has no storage: redirect to pointer contents
  assign file_addr = is_window ? file_pointer_ff[file_reg[0]]
                   : 16'({bank_select_register_ff, file_reg});
  assign file_idx = file_addr[MEM_AW-1:0];
  assign operand = mem[file_idx];
  assign sel_ptr = file_pointer_ff[instr.sel];
  assign ind_data = mem[eff_addr[MEM_AW-1:0]];

  shift_unit u_shift (
    .operand(operand),
    .load_value(ind_data),
    .shift_result(shift_result),
    .shift_carry(shift_carry),
    .shift_zero(shift_zero),
    .load_zero(load_zero)
  );

  pointer_unit u_ptr (
    .ptr(sel_ptr),
    .pointer_mode_code(instr.pointer_mode_code),
    .rel(instr.rel),
    .offset(instr.offset),
    .eff_addr(eff_addr),
    .nxt_ptr(nxt_ptr)
  );

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    rd_value = 32'h0000_0000;
    if (paddr == sm_exec_pkg::OFF_INSTR) begin
      rd_value = 32'h0000_0000;
    end else if (paddr == sm_exec_pkg::OFF_WORK) begin
      rd_value[7:0] = work_ff;
    end else if (paddr == sm_exec_pkg::OFF_STATUS) begin
      rd_value[sm_exec_pkg::STATUS_C_BIT] = flags_ff.c;
      rd_value[sm_exec_pkg::STATUS_Z_BIT] = flags_ff.z;
    end else if (paddr == sm_exec_pkg::OFF_BANK) begin
      rd_value[sm_exec_pkg::BANK_W-1:0] = bank_select_register_ff;
    end else if (paddr == sm_exec_pkg::OFF_PAGE) begin
      rd_value[sm_exec_pkg::PAGE_W-1:0] = program_counter_upper_latch_ff;
    end else if (paddr == sm_exec_pkg::OFF_PTR0) begin
      rd_value[15:0] = file_pointer_ff[0];
    end else if (paddr == sm_exec_pkg::OFF_PTR1) begin
      rd_value[15:0] = file_pointer_ff[1];
    end else if (paddr == sm_exec_pkg::OFF_MEM_ADDR) begin
      rd_value[MEM_AW-1:0] = mem_addr_ff;
    end else if (paddr == sm_exec_pkg::OFF_MEM_DATA) begin
      rd_value[7:0] = mem[mem_addr_ff];
    end else begin
      mapped = 1'b0;
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      prdata_ff <= rd_value;
    end
  end

  // ---------------------------------------------------------------
  // architectural registers
  // ---------------------------------------------------------------
  // work register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_ff <= sm_exec_pkg::WORK_RST;
    end else if (exec) begin
      if (instr.opcode == sm_exec_pkg::OP_SHIFT_RIGHT && !instr.dest) begin
        work_ff <= shift_result;
      end else if (instr.opcode == sm_exec_pkg::OP_IND_LOAD) begin
        work_ff <= ind_data;
      end else if (instr.opcode == sm_exec_pkg::OP_WORK_LIT) begin
        work_ff <= instr.literal;
      end
    end else if (wr && paddr == sm_exec_pkg::OFF_WORK) begin
      work_ff <= pwdata[7:0];
    end
  end

  // carry and zero flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= '0;
    end else if (exec) begin
      if (instr.opcode == sm_exec_pkg::OP_SHIFT_RIGHT) begin
        flags_ff.c <= shift_carry;
        flags_ff.z <= shift_zero;
      end else if (instr.opcode == sm_exec_pkg::OP_IND_LOAD) begin
        flags_ff.z <= load_zero;
      end
    end else if (wr && paddr == sm_exec_pkg::OFF_STATUS) begin
      flags_ff.c <= pwdata[sm_exec_pkg::STATUS_C_BIT];
      flags_ff.z <= pwdata[sm_exec_pkg::STATUS_Z_BIT];
    end
  end

  // bank select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_select_register_ff <= sm_exec_pkg::BANK_RST;
    end else if (exec && instr.opcode == sm_exec_pkg::OP_BANK_LIT) begin
      bank_select_register_ff <= instr.literal[sm_exec_pkg::BANK_W-1:0];
    end else if (wr && paddr == sm_exec_pkg::OFF_BANK) begin
      bank_select_register_ff <= pwdata[sm_exec_pkg::BANK_W-1:0];
    end
  end

  // program counter upper latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter_upper_latch_ff <= sm_exec_pkg::PAGE_RST;
    end else if (exec && instr.opcode == sm_exec_pkg::OP_PAGE_LIT) begin
      program_counter_upper_latch_ff <=
        instr.literal[sm_exec_pkg::PAGE_W-1:0];
    end else if (wr && paddr == sm_exec_pkg::OFF_PAGE) begin
      program_counter_upper_latch_ff <= pwdata[sm_exec_pkg::PAGE_W-1:0];
    end
  end

  // the two file pointers
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    logic [7:0] ptr_off;
    assign ptr_off = (i == 1) ? sm_exec_pkg::OFF_PTR1 : sm_exec_pkg::OFF_PTR0;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        file_pointer_ff[i] <= sm_exec_pkg::PTR_RST;
      end else if (exec && instr.opcode == sm_exec_pkg::OP_IND_LOAD &&
                   instr.sel == 1'(i)) begin
        file_pointer_ff[i] <= nxt_ptr;
      end else if (wr && paddr == ptr_off) begin
        file_pointer_ff[i] <= pwdata[15:0];
      end
    end
  end

  // software window into data memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr_ff <= '0;
    end else if (wr && paddr == sm_exec_pkg::OFF_MEM_ADDR) begin
      mem_addr_ff <= pwdata[MEM_AW-1:0];
    end
  end

  // data memory write port
  always_ff @(posedge pclk) begin
    if (exec && instr.opcode == sm_exec_pkg::OP_SHIFT_RIGHT && instr.dest) begin
      mem[file_idx] <= shift_result;
    end else if (exec && instr.opcode == sm_exec_pkg::OP_STORE_WORK) begin
      mem[file_idx] <= work_ff;
    end else if (wr && paddr == sm_exec_pkg::OFF_MEM_DATA) begin
      mem[mem_addr_ff] <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic op_shift;
  logic op_ind;
  assign op_shift = exec && instr.opcode == sm_exec_pkg::OP_SHIFT_RIGHT;
  assign op_ind = exec && instr.opcode == sm_exec_pkg::OP_IND_LOAD;

  shift_result_a: assert property (
    op_shift && !instr.dest |=> work_ff[7] == 1'b0 &&
      work_ff[6:0] == $past(operand[7:1]) && flags_ff.c == $past(operand[0]))
    else $error("right shift result or carry wrong");

  shift_dest_a: assert property (
    op_shift && instr.dest |=> work_ff == $past(work_ff) &&
      mem[$past(file_idx)] == $past(shift_result))
    else $error("shift to file changed work or missed file");

  window_redirect_a: assert property (
    exec && is_window && instr.opcode == sm_exec_pkg::OP_STORE_WORK |=>
      mem[$past(file_pointer_ff[file_reg[0]][MEM_AW-1:0])] == $past(work_ff))
    else $error("window store missed the pointed location");

  ind_load_a: assert property (
    op_ind |=> work_ff == $past(ind_data) && flags_ff.c == $past(flags_ff.c)
      && flags_ff.z == (work_ff == 8'h00))
    else $error("indirect load data or flags wrong");

  pre_inc_a: assert property (
    op_ind && !instr.rel && instr.pointer_mode_code ==
      sm_exec_pkg::MODE_PRE_INC |-> eff_addr == sel_ptr + 16'h0001
      ##1 file_pointer_ff[$past(instr.sel)] == $past(eff_addr))
    else $error("pre-increment wrong");

  post_dec_a: assert property (
    op_ind && !instr.rel && instr.pointer_mode_code ==
      sm_exec_pkg::MODE_POST_DEC |-> eff_addr == sel_ptr
      ##1 file_pointer_ff[$past(instr.sel)] == $past(sel_ptr) - 16'h0001)
    else $error("post-decrement wrong");

  rel_keep_a: assert property (
    op_ind && instr.rel |=>
      file_pointer_ff[$past(instr.sel)] == $past(sel_ptr))
    else $error("relative mode moved the pointer");

  ptr_wrap_a: assert property (
    op_ind && !instr.rel && sel_ptr == 16'hFFFF &&
      instr.pointer_mode_code == sm_exec_pkg::MODE_POST_INC |=>
      file_pointer_ff[$past(instr.sel)] == 16'h0000)
    else $error("pointer did not wrap");

  bank_load_a: assert property (
    exec && instr.opcode == sm_exec_pkg::OP_BANK_LIT |=>
      bank_select_register_ff == $past(instr.literal[4:0]) &&
      $stable(flags_ff))
    else $error("bank literal load wrong");

  page_load_a: assert property (
    exec && instr.opcode == sm_exec_pkg::OP_PAGE_LIT |=>
      program_counter_upper_latch_ff == $past(instr.literal[6:0]) &&
      $stable(flags_ff))
    else $error("page literal load wrong");

  work_lit_a: assert property (
    exec && instr.opcode == sm_exec_pkg::OP_WORK_LIT |=>
      work_ff == $past(instr.literal) && $stable(flags_ff))
    else $error("work literal load wrong");

  store_work_a: assert property (
    exec && instr.opcode == sm_exec_pkg::OP_STORE_WORK |=>
      mem[$past(file_idx)] == $past(work_ff) && $stable(flags_ff))
    else $error("store of work wrong");

  shift_zero_a: assert property (
    op_shift |=> flags_ff.z == ($past(operand[7:1]) == 7'h00))
    else $error("zero flag after shift wrong");

  shift_cov: cover property (op_shift && instr.dest);
  ind_rel_cov: cover property (op_ind && instr.rel);
  wrap_cov: cover property (op_ind && sel_ptr == 16'h0000 &&
    instr.pointer_mode_code == sm_exec_pkg::MODE_PRE_DEC && !instr.rel);
  window_cov: cover property (exec && is_window &&
    instr.opcode == sm_exec_pkg::OP_STORE_WORK);

endmodule : shift_and_move_instruction_exec

// >>> shift_and_move_instruction_exec_tb_top.sv
// self-checking bench for the shift and move execution block
`timescale 1ns/1ps
module shift_and_move_instruction_exec_tb_top;
  // expected outcome of one apb transfer
  typedef struct packed {
    logic rd;
    logic err;
    logic [31:0] data;
  } note_type;

  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  note_type notes[$];
  note_type cur;
  int err_total;
  int n_compared;
  int seed;
  logic [7:0] v;
  logic [7:0] r;
  logic [15:0] p;
  logic [15:0] e;
  logic [15:0] np;
  logic [5:0] k;
  logic [4:0] b;
  logic [6:0] f;
  logic sl;
  logic [7:0] pa;
  sm_exec_pkg::instr_type ins;

  shift_and_move_instruction_exec #(
    .MEM_AW(8)
  ) u_shift_and_move_instruction_exec (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // free-running 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // checking and reporting
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: data %h expected %h", $time, got, exp);
    end
  endtask : cmp_data

  task automatic cmp_err(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: slverr %h expected %h", $time, got, exp);
    end
  endtask : cmp_err

  // monitor: pops the oldest note at every completed access
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
        && notes.size() > 0) begin
      cur = notes.pop_front();
      cmp_err(pslverr, cur.err);
      if (cur.rd) begin
        cmp_data(prdata, cur.data);
      end
    end
  end

  // ---------------------------------------------------------------
  // apb master tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] x,
                     input logic er);
    int n;
    notes.push_back('{rd: !wr, err: er, data: x});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      stop_test();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, x, 1'b0);
  endtask : rd

  task automatic ex(input logic [7:0] op, input logic [7:0] lit,
                    input logic dst = 1'b0, input logic s = 1'b0,
                    input logic [1:0] md = 2'h0, input logic rl = 1'b0,
                    input logic [5:0] ko = 6'h00);
    ins = '{5'h00, ko, rl, md, s, dst, lit, op};
    wr(sm_exec_pkg::OFF_INSTR, ins);
  endtask : ex

  task automatic mset(input logic [7:0] a, input logic [7:0] d);
    wr(sm_exec_pkg::OFF_MEM_ADDR, {24'h0, a});
    wr(sm_exec_pkg::OFF_MEM_DATA, {24'h0, d});
  endtask : mset

  task automatic mchk(input logic [7:0] a, input logic [7:0] x);
    wr(sm_exec_pkg::OFF_MEM_ADDR, {24'h0, a});
    rd(sm_exec_pkg::OFF_MEM_DATA, {24'h0, x});
  endtask : mchk

  // main sequence
  initial begin
    seed = 32'h3EA4;
    err_total = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = sm_exec_pkg::STRB_ALL;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, write-only instruction word, unmapped address
    rd(sm_exec_pkg::OFF_WORK, 32'h0);
    rd(sm_exec_pkg::OFF_STATUS, 32'h0);
    rd(sm_exec_pkg::OFF_BANK, 32'h0);
    rd(sm_exec_pkg::OFF_PAGE, 32'h0);
    rd(sm_exec_pkg::OFF_PTR0, 32'h0);
    rd(sm_exec_pkg::OFF_PTR1, 32'h0);
    rd(sm_exec_pkg::OFF_INSTR, 32'h0);
    apb(1'b0, 8'h24, 32'h0, 32'h0, 1'b1);
    // literal loads keep both flags
    wr(sm_exec_pkg::OFF_STATUS, 32'h5);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
      ex(sm_exec_pkg::OP_WORK_LIT, v);
      rd(sm_exec_pkg::OFF_WORK, {24'h0, v});
      ex(sm_exec_pkg::OP_BANK_LIT, {3'h0, v[4:0]});
      rd(sm_exec_pkg::OFF_BANK, {27'h0, v[4:0]});
      ex(sm_exec_pkg::OP_PAGE_LIT, {1'b0, v[6:0]});
      rd(sm_exec_pkg::OFF_PAGE, {25'h0, v[6:0]});
      rd(sm_exec_pkg::OFF_STATUS, 32'h5);
    end
    // write without strobes is ignored
    pstrb <= 4'h0;
    wr(sm_exec_pkg::OFF_WORK, 32'hAA);
    // instruction without all strobes does not execute
    pstrb <= 4'h1;
    ex(sm_exec_pkg::OP_WORK_LIT, 8'h33);
    pstrb <= sm_exec_pkg::STRB_ALL;
    rd(sm_exec_pkg::OFF_WORK, {24'h0, v});
    // unknown opcode is a no-operation
    ex(8'h07, 8'h5A);
    rd(sm_exec_pkg::OFF_WORK, {24'h0, v});
    rd(sm_exec_pkg::OFF_STATUS, 32'h5);
    // store to banked file, then right shift to either destination
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($random(seed));
      b = 5'($random(seed));
      f = 7'h7F - 7'(i * 5);
      pa = {b[0], f};
      wr(sm_exec_pkg::OFF_STATUS, 32'h5);
      ex(sm_exec_pkg::OP_BANK_LIT, {3'h0, b});
      ex(sm_exec_pkg::OP_WORK_LIT, v);
      ex(sm_exec_pkg::OP_STORE_WORK, {1'b0, f});
      mchk(pa, v);
      rd(sm_exec_pkg::OFF_STATUS, 32'h5);
      r = {1'b0, v[7:1]};
      ex(sm_exec_pkg::OP_SHIFT_RIGHT, {1'b0, f}, i[0]);
      mchk(pa, i[0] ? r : v);
      rd(sm_exec_pkg::OFF_WORK, {24'h0, i[0] ? v : r});
      rd(sm_exec_pkg::OFF_STATUS, {29'h0, r == 8'h00, 1'b0, v[0]});
    end
    // indirect load over all modes, both pointers, wrap and offsets
    for (int i = 0; i < 12; i++) begin
      p = (i < 4) ? {16{~i[0]}} : 16'($random(seed));
      k = (i == 8) ? 6'h20 : (i == 9) ? 6'h1F : 6'($random(seed));
      sl = (i < 8) ? i[2] : i[0];
      v = (i == 5) ? 8'h00 : 8'($random(seed));
      case (i[1:0])
        2'h0: begin e = p + 16'h1; np = e; end
        2'h1: begin e = p - 16'h1; np = e; end
        2'h2: begin e = p; np = p + 16'h1; end
        default: begin e = p; np = p - 16'h1; end
      endcase
      if (i >= 8) begin
        e = p + {{10{k[5]}}, k};
        np = p;
      end
      wr(sm_exec_pkg::OFF_STATUS, {31'h0, i[0]});
      mset(e[7:0], v);
      wr(sm_exec_pkg::OFF_PTR0 + 8'(4 * sl), {16'h0, p});
      ex(sm_exec_pkg::OP_IND_LOAD, 8'h00, 1'b0, sl, i[1:0], i >= 8, k);
      rd(sm_exec_pkg::OFF_WORK, {24'h0, v});
      rd(sm_exec_pkg::OFF_PTR0 + 8'(4 * sl), {16'h0, np});
      rd(sm_exec_pkg::OFF_STATUS, {29'h0, v == 8'h00, 1'b0, i[0]});
    end
    // store and shift through the two indirect windows
    for (int i = 0; i < 2; i++) begin
      p = 16'($random(seed));
      v = 8'($random(seed));
      wr(sm_exec_pkg::OFF_PTR0 + 8'(4 * i), {16'h0, p});
      ex(sm_exec_pkg::OP_WORK_LIT, v);
      ex(sm_exec_pkg::OP_STORE_WORK, 8'(i));
      mchk(p[7:0], v);
      ex(sm_exec_pkg::OP_SHIFT_RIGHT, 8'(i), 1'b1);
      mchk(p[7:0], {1'b0, v[7:1]});
      rd(sm_exec_pkg::OFF_PTR0 + 8'(4 * i), {16'h0, p});
    end
    repeat (2) @(posedge pclk);
    stop_test();
  end
endmodule : shift_and_move_instruction_exec_tb_top
